//--- led_stage_pkg.sv
// Purpose: shared constants for the led output stage and soft reset watcher
// Assumes: 32-bit ahb-lite register bus, byte addresses
// Notes: mode and channel defaults are zero, as after power-up; status reads 1 (oe bit)
package led_stage_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CHAN = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;

  // ==========================================================
  // mode and channel register fields
  localparam int MODE_W = 5;
  localparam int MODE_INV_BIT = 0;
  localparam int MODE_TOTEM_BIT = 1;
  localparam int MODE_DOS_LSB = 2;
  localparam int MODE_BLINK_BIT = 4;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam int CHAN_W = 16;
  localparam logic [CHAN_W-1:0] CHAN_RST = 16'h0000;

  // ==========================================================
  // status register fields
  localparam int STAT_OE_BIT = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_CNT_W = 8;

  // ==========================================================
  // channel state and disabled-output codes
  localparam logic [1:0] CH_OFF = 2'h0;
  localparam logic [1:0] CH_ON = 2'h1;
  localparam logic [1:0] CH_IND = 2'h2;
  localparam logic [1:0] CH_GRP = 2'h3;
  localparam logic [1:0] DOS_LOW = 2'h0;
  localparam logic [1:0] DOS_HIGH = 2'h1;

  // ==========================================================
  // bus constants
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ==========================================================
  // soft reset call bytes
  localparam logic [7:0] SRST_ADDR_BYTE = 8'h06;
  localparam logic [7:0] SRST_KEY1 = 8'hA5;
  localparam logic [7:0] SRST_KEY2 = 8'h5A;
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage

//--- soft_reset_watch.sv
// Purpose: watches the two-wire bus for the soft reset call and acks it
// Assumes: scl and sda arrive asynchronously, sampled by hclk
// Notes: only this call is recognised; all other traffic is ignored
`timescale 1ns/1ps
module soft_reset_watch
  import led_stage_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // result
  output logic soft_reset_pulse
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_KEY1, ST_KEY2, ST_ARMED} srst_state_t;

  srst_state_t state_reg, state_next;
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic [3:0] bits_reg, bits_next;
  logic [7:0] shift_reg, shift_next;
  logic oe_reg, oe_next, pulse_reg, pulse_next;

  // ==========================================================
  // edge and condition detection
  wire scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg & scl_prev_reg;
  wire start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  wire byte_full = (bits_reg == BYTE_BITS);
  wire byte_hit = (state_reg == ST_ADDR && shift_reg == SRST_ADDR_BYTE) ||
                  (state_reg == ST_KEY1 && shift_reg == SRST_KEY1) ||
                  (state_reg == ST_KEY2 && shift_reg == SRST_KEY2);
  wire [2:0] adv_state = (state_reg == ST_ADDR) ? 3'(ST_KEY1) :
                         (state_reg == ST_KEY1) ? 3'(ST_KEY2) : 3'(ST_ARMED);

  always_comb begin
    state_next = state_reg;
    bits_next = bits_reg;
    shift_next = shift_reg;
    oe_next = oe_reg;
    pulse_next = 1'b0;
    if (stop_det) begin
      // reset fires only on a fully keyed stop
      pulse_next = (state_reg == ST_ARMED);
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_det) begin
      state_next = ST_ADDR;
      bits_next = 4'h0;
      oe_next = 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise && !oe_reg && !byte_full) begin
        shift_next = {shift_reg[6:0], sda_sync_reg};
        bits_next = bits_reg + 4'h1;
      end else if (scl_fall && oe_reg) begin
        oe_next = 1'b0;
        bits_next = 4'h0;
      end else if (scl_fall && byte_full) begin
        // wrong or extra byte: no ack, back to idle
        if (byte_hit) begin
          oe_next = 1'b1;
          state_next = srst_state_t'(adv_state);
        end else begin
          state_next = ST_IDLE;
        end
        bits_next = 4'h0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= 3'h7;
      {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= 3'h7;
      state_reg <= ST_IDLE;
      bits_reg <= 4'h0;
      shift_reg <= 8'h00;
      oe_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= {scl_in, scl_meta_reg, scl_sync_reg};
      {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= {sda_in, sda_meta_reg, sda_sync_reg};
      state_reg <= state_next;
      bits_reg <= bits_next;
      shift_reg <= shift_next;
      oe_reg <= oe_next;
      pulse_reg <= pulse_next;
    end
  end

  assign sda_oe = oe_reg;
  assign soft_reset_pulse = pulse_reg;

  // ==========================================================
  // checks
  ack_on_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(oe_reg) |-> $past(byte_hit) && $past(scl_fall))
    else $error("ack driven without matching byte");
  no_extra_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_ARMED && scl_fall && byte_full && !stop_det && !start_det |=> !oe_reg)
    else $error("byte after second key acknowledged");
  reset_on_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_reg |-> $past(state_reg) == ST_ARMED && $past(stop_det))
    else $error("soft reset without full call");
  ack_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_det |=> !oe_reg && state_reg == ST_IDLE)
    else $error("stop did not return watcher to idle");
  ack_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(oe_reg));

endmodule // soft_reset_watch

//--- led_output_stage.sv
// Purpose: output stage of an eight-channel led driver with soft reset call
// Assumes: pwm sources on hclk; oe_n, scl, sda asynchronous pins
// Notes: registers on ahb-lite, zero wait states, always OKAY
`timescale 1ns/1ps
module led_output_stage
  import led_stage_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pwm sources
  input wire logic [CHANNELS-1:0] ind_pwm,
  input wire logic grp_pwm,
  // pins
  input wire logic oe_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // output transistors and group mode
  output logic [CHANNELS-1:0] led_high_en,
  output logic [CHANNELS-1:0] led_low_en,
  output logic group_blink_select
);

  // ==========================================================
  // drive function: returns {upper, lower}
  function automatic logic [1:0] pin_drive(
    input logic [1:0] st,
    input logic ind,
    input logic grp,
    input logic inv,
    input logic totem,
    input logic oe_hi,
    input logic [1:0] dos
  );
    logic act;
    logic low_on;
    begin
      act = (st == CH_ON) | ((st == CH_IND) & ind) | ((st == CH_GRP) & ind & grp);
      low_on = act ^ inv;
      if (oe_hi) begin
        pin_drive = {(dos == DOS_HIGH) & totem, dos == DOS_LOW};
      end else begin
        // upper is complement, only in totem
        pin_drive = {totem & ~low_on, low_on};
      end
    end
  endfunction

  // ==========================================================
  // read decode function
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input logic [MODE_W-1:0] mode,
    input logic [CHAN_W-1:0] chan,
    input logic [31:0] stat
  );
    begin
      case (addr)
        ADDR_MODE: read_word = {{(32-MODE_W){1'b0}}, mode};
        ADDR_CHAN: read_word = {{(32-CHAN_W){1'b0}}, chan};
        ADDR_STAT: read_word = stat;
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // ==========================================================
  // declarations
  logic [MODE_W-1:0] mode_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [STAT_CNT_W-1:0] srst_cnt_reg;
  logic [7:0] addr_reg;
  logic wr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic oe_meta_reg;
  logic oe_sync_reg;
  logic [CHANNELS-1:0] led_high_reg;
  logic [CHANNELS-1:0] led_low_reg;
  logic [CHANNELS-1:0] led_high_next;
  logic [CHANNELS-1:0] led_low_next;
  logic blink_reg;
  logic sda_out_reg;
  logic srst_pulse;

  // ==========================================================
  // soft reset call watcher
  soft_reset_watch u_watch (
    .hclk (hclk),
    .hresetn (hresetn),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .sda_oe (sda_oe),
    .soft_reset_pulse (srst_pulse)
  );

  // ==========================================================
  // bus decode
  wire take = hsel & hready & htrans[1];
  wire take_wr = take & hwrite & (hsize == SIZE_WORD);
  wire take_rd = take & ~hwrite;
  wire wr_mode = wr_reg & (addr_reg == ADDR_MODE);
  wire wr_chan = wr_reg & (addr_reg == ADDR_CHAN);

  // soft reset restores defaults, wins over a write
  wire [MODE_W-1:0] mode_next = srst_pulse ? MODE_RST :
                                wr_mode ? hwdata[MODE_W-1:0] : mode_reg;
  wire [CHAN_W-1:0] chan_next = srst_pulse ? CHAN_RST :
                                wr_chan ? hwdata[CHAN_W-1:0] : chan_reg;
  wire [STAT_CNT_W-1:0] srst_cnt_next = srst_cnt_reg + STAT_CNT_W'(srst_pulse);

  wire [31:0] stat_word = (32'(srst_cnt_reg) << STAT_CNT_LSB) |
                          (32'(oe_sync_reg) << STAT_OE_BIT);
  // read uses next values so a read right after a write sees it
  wire [31:0] hrdata_next = take_rd ? read_word(haddr[7:0], mode_next, chan_next, stat_word) :
                            32'h0000_0000;

  // ==========================================================
  // mode fields
  wire inv_bit = mode_reg[MODE_INV_BIT];
  wire totem_bit = mode_reg[MODE_TOTEM_BIT];
  wire [1:0] dos_field = mode_reg[MODE_DOS_LSB +: 2];

  // ==========================================================
  // output stage
  always_comb begin
    led_high_next = '0;
    led_low_next = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      // every channel shares the same oe level
      {led_high_next[i], led_low_next[i]} = pin_drive(chan_reg[2*i +: 2], ind_pwm[i], grp_pwm,
                                                      inv_bit, totem_bit, oe_sync_reg, dos_field);
    end
  end

  // ==========================================================
  // bus registers
  // power-on reset clears everything but hreadyout_reg, which resets to 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
    end else begin
      if (hready) begin
        addr_reg <= haddr[7:0];
        wr_reg <= take_wr;
      end
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_RST;
      chan_reg <= CHAN_RST;
      srst_cnt_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      chan_reg <= chan_next;
      srst_cnt_reg <= srst_cnt_next;
    end
  end

  // ==========================================================
  // pin sync and outputs
  // oe_n is asynchronous; the 2-cycle latency is the price of a clean sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_meta_reg <= 1'b1;
      oe_sync_reg <= 1'b1;
    end else begin
      oe_meta_reg <= oe_n;
      oe_sync_reg <= oe_meta_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_high_reg <= '0;
      led_low_reg <= '0;
      blink_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      led_high_reg <= led_high_next;
      led_low_reg <= led_low_next;
      blink_reg <= mode_reg[MODE_BLINK_BIT];
      sda_out_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign sda_out = sda_out_reg;
  assign led_high_en = led_high_reg;
  assign led_low_en = led_low_reg;
  assign group_blink_select = blink_reg;

  // ==========================================================
  // checks
  // one channel per state code, so every decode branch is exercised
  wire [1:0] ch0_state = chan_reg[1:0];
  wire [1:0] ch1_state = chan_reg[3:2];
  wire [1:0] ch2_state = chan_reg[5:4];
  wire [1:0] ch3_state = chan_reg[7:6];

  dis_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oe_sync_reg && dos_field == DOS_LOW |=> led_low_en == '1 && led_high_en == '0)
    else $error("disabled low level wrong");
  dis_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oe_sync_reg && dos_field == DOS_HIGH |=>
      led_high_en == {CHANNELS{$past(totem_bit)}} && led_low_en == '0)
    else $error("disabled high level wrong");
  open_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !totem_bit |=> led_high_en == '0)
    else $error("upper transistor on in open-drain");
  off_plain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && !inv_bit && ch0_state == CH_OFF |=> !led_low_en[0])
    else $error("off channel sinks current");
  on_plain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && !inv_bit && ch1_state == CH_ON |=> led_low_en[1] && !led_high_en[1])
    else $error("on channel not sinking");
  inv_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && inv_bit && ch0_state == CH_OFF |=> led_low_en[0] && !led_high_en[0])
    else $error("inverted off channel wrong");
  ind_pwm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && !inv_bit && ch2_state == CH_IND |=> led_low_en[2] == $past(ind_pwm[2]))
    else $error("individual pwm not passed");
  grp_pwm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && !inv_bit && ch3_state == CH_GRP |=>
      led_low_en[3] == ($past(ind_pwm[3]) & $past(grp_pwm)))
    else $error("group pwm not combined");
  oe_latency_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(oe_n) ##1 oe_n [*2] |-> oe_sync_reg)
    else $error("oe not seen within two cycles");
  srst_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    srst_pulse |=> mode_reg == MODE_RST && chan_reg == CHAN_RST)
    else $error("soft reset did not clear registers");
  srst_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !srst_pulse |=> srst_cnt_reg == $past(srst_cnt_reg))
    else $error("reset count moved without soft reset");
  por_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> mode_reg == MODE_RST && chan_reg == CHAN_RST)
    else $error("registers not cleared by reset");

  // ==========================================================
  // enabled and disabled drive, per state code
  totem_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && !inv_bit && totem_bit && ch0_state == CH_OFF |=> led_high_en[0] && !led_low_en[0])
    else $error("totem off channel not driven high");
  inv_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && inv_bit && ch1_state == CH_ON |=>
      !led_low_en[1] && led_high_en[1] == $past(totem_bit))
    else $error("inverted on channel wrong");
  inv_ind_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && inv_bit && ch2_state == CH_IND |=> led_low_en[2] == !$past(ind_pwm[2]))
    else $error("inverted pwm not complemented");
  inv_grp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && inv_bit && ch3_state == CH_GRP |=>
      led_low_en[3] == !($past(ind_pwm[3]) & $past(grp_pwm)))
    else $error("inverted group pwm not complemented");
  upper_comp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && totem_bit |=> led_high_en == ~led_low_en)
    else $error("upper transistor not complement of lower");
  // shoot-through guard: upper and lower never on together
  no_overlap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_high_en & led_low_en) == '0)
    else $error("both transistors of a channel on");
  dis_hiz_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oe_sync_reg && dos_field[1] |=> led_high_en == '0 && led_low_en == '0)
    else $error("disabled high impedance level wrong");
  dis_same_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oe_sync_reg |=>
      led_low_en == {CHANNELS{led_low_en[0]}} && led_high_en == {CHANNELS{led_high_en[0]}})
    else $error("disabled channels differ");
  pol_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oe_sync_reg && inv_bit |=>
      led_low_en == {CHANNELS{$past(dos_field) == DOS_LOW}})
    else $error("polarity applied while disabled");
  // latency bound: two sync flops into oe_sync_reg, output register not included
  oe_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(oe_n) ##1 !oe_n [*2] |-> !oe_sync_reg)
    else $error("oe low not seen within two cycles");

  // ==========================================================
  // register keeping checks
  srst_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !srst_pulse && !wr_mode && !wr_chan |=> mode_reg == $past(mode_reg) && chan_reg == $past(chan_reg))
    else $error("registers changed without write or soft reset");
  srst_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    srst_pulse |=> srst_cnt_reg == $past(srst_cnt_reg) + 1'b1)
    else $error("soft reset not counted");

  srst_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) srst_pulse);
  oe_off_c: cover property (@(posedge hclk) disable iff (!hresetn) oe_sync_reg && totem_bit);
  grp_mode_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !oe_sync_reg && ch3_state == CH_GRP && inv_bit);
  oe_on_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(oe_sync_reg));

endmodule // led_output_stage

//--- i2c_master_model.sv
// Purpose: two-wire bus master driving the soft reset call
// Assumes: sda has a pull-up; the device pulls it low to ack
// Notes: scl stands high between frames; sda changes mid scl-low
`timescale 1ns/1ps
module i2c_master_model (
  // bus pins
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ==========================================================
  // timing
  localparam time Q = 80;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ==========================================================
  // frame tasks
  // start then call bytes
  task automatic start_c();
    sda_low = 1'b1;
    #(2*Q);
    scl = 1'b0;
  endtask
  task automatic rstart();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop_c();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) begin
      #Q sda_low = ~b[i];
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
    end
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q ack = ~sda_line;
    #Q scl = 1'b0;
  endtask
endmodule // i2c_master_model

//--- tb_led_output_stage.sv
// Purpose: self-checking bench for the led output stage
// Assumes: zero-wait ahb-lite slave, bus master model on scl/sda
// Notes: expectations come from the bench's own output table
`timescale 1ns/1ps
module tb_led_output_stage;
  import led_stage_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] ind_pwm = 8'h00;
  logic grp_pwm = 1'b0;
  logic oe_n = 1'b1;
  wire hready;
  wire [31:0] hrdata;
  wire hresp;
  wire scl;
  wire sda_low;
  wire sda_oe;
  wire sda_out;
  wire sda_in;
  wire [7:0] led_high_en;
  wire [7:0] led_low_en;
  wire group_blink_select;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [4:0] md;
  int m;
  always #20 hclk = ~hclk;
  // pull-up: low if either party pulls
  assign sda_in = ~(sda_low | sda_oe);
  led_output_stage DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .ind_pwm(ind_pwm), .grp_pwm(grp_pwm), .oe_n(oe_n), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .led_high_en(led_high_en), .led_low_en(led_low_en),
    .group_blink_select(group_blink_select));
  i2c_master_model master (.scl(scl), .sda_low(sda_low), .sda_line(sda_in));
  // ==========================================================
  // checking and closing
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] exp, input logic [31:0] act);
    compares++;
    if (act !== exp) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  initial begin
    #3_000_000;
    fail_count++;
    report_and_stop();
  end
  // ==========================================================
  // ahb-lite master
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= SIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0000_0000, r);
    check(exp, r);
  endtask
  // ==========================================================
  // output table of the bench
  function automatic logic [31:0] led_exp(input logic [4:0] mo, input logic [15:0] ch, input logic [7:0] ind,
                                          input logic grp, input logic oe);
    logic [7:0] hi;
    logic [7:0] lo;
    logic a;
    logic d;
    int i;
    for (i = 0; i < 8; i++) begin
      case (ch[2*i +: 2])
        2'h0: a = 1'b0;
        2'h1: a = 1'b1;
        2'h2: a = ind[i];
        default: a = ind[i] & grp;
      endcase
      d = a ^ mo[0];
      lo[i] = oe ? (mo[3:2] == 2'h0) : d;
      hi[i] = oe ? (mo[3:2] == 2'h1 && mo[1]) : (mo[1] & ~d);
    end
    return {16'h0000, hi, lo};
  endfunction
  task automatic led_chk(input logic [4:0] mo);
    xfer(ADDR_MODE, 1'b1, {27'h000_0000, mo}, rd);
    repeat (4) @(posedge hclk);
    check(led_exp(mo, 16'hE4E4, ind_pwm, grp_pwm, oe_n), {16'h0000, led_high_en, led_low_en});
    check({31'h0000_0000, mo[4]}, {31'h0000_0000, group_blink_select});
  endtask
  // ==========================================================
  // soft reset call
  task automatic srst(input logic [31:0] b, input int n, input logic [3:0] exp, input logic rs);
    logic ack;
    int i;
    @(posedge hclk);
    #7;
    master.start_c();
    for (i = 0; i < n; i++) begin
      master.send_byte(b[31-8*i -: 8], ack);
      check({31'h0000_0000, exp[i]}, {31'h0000_0000, ack});
      if (ack !== 1'b1) break;
    end
    if (rs) master.rstart();
    master.stop_c();
    repeat (10) @(posedge hclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_MODE, 32'h0000_0000);
    rd_chk(ADDR_CHAN, 32'h0000_0000);
    rd_chk(ADDR_STAT, 32'h0000_0001);
    rd_chk(8'h0C, 32'h0000_0000);
    xfer(ADDR_CHAN, 1'b1, 32'h0000_E4E4, rd);
    rd_chk(ADDR_CHAN, 32'h0000_E4E4);
    for (m = 0; m < 8; m++) begin
      led_chk({1'b0, m[2:1], m[0], m[1]});
    end
    // oe_n only toggled between settled phases
    @(posedge hclk);
    oe_n <= 1'b0;
    // two sync flops before the status bit can follow the pin
    repeat (2) @(posedge hclk);
    rd_chk(ADDR_STAT, 32'h0000_0000);
    for (m = 0; m < 8; m++) begin
      @(posedge hclk);
      ind_pwm <= m[2] ? 8'h39 : 8'hC6;
      grp_pwm <= m[1] ^ m[0];
      led_chk({m[2], 2'h0, m[1], m[0]});
    end
    md = 5'h0B;
    xfer(ADDR_MODE, 1'b1, {27'h000_0000, md}, rd);
    srst(32'h0700_0000, 1, 4'h0, 1'b0);
    srst(32'h0600_0000, 2, 4'h1, 1'b0);
    srst(32'h06A5_0000, 3, 4'h3, 1'b0);
    srst(32'h06A5_0000, 2, 4'h3, 1'b1);
    rd_chk(ADDR_MODE, {27'h000_0000, md});
    srst(32'h06A5_5A00, 3, 4'h7, 1'b0);
    rd_chk(ADDR_MODE, 32'h0000_0000);
    rd_chk(ADDR_CHAN, 32'h0000_0000);
    rd_chk(ADDR_STAT, 32'h0000_0100);
    srst(32'h06A5_5A00, 4, 4'h7, 1'b0);
    // oe_n high again: every output drops to the disabled level together
    @(posedge hclk);
    oe_n <= 1'b1;
    repeat (4) @(posedge hclk);
    check(led_exp(5'h00, 16'h0000, ind_pwm, grp_pwm, 1'b1), {16'h0000, led_high_en, led_low_en});
    rd_chk(ADDR_STAT, 32'h0000_0101);
    check(32'h0000_0000, {30'h0000_0000, hresp, sda_out});
    report_and_stop();
  end
endmodule // tb_led_output_stage
